// [rtl/slow_tb_pkg.sv]
// constants, register map and field layout of the slow time base counter
package slow_tb_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_TAP_VALUE = 16'hf060;
   localparam logic [15:0] IDX_CONTROL = 16'hf062;
   localparam logic [15:0] IDX_RTC_TAP = 16'hf064;
   localparam logic [15:0] IDX_TRIM_LOW = 16'hf066;
   localparam logic [15:0] IDX_TRIM_HIGH = 16'hf067;
   localparam logic [15:0] IDX_SEL_LOW = 16'hf068;
   localparam logic [15:0] IDX_SEL_HIGH = 16'hf069;
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h01;
   localparam logic [7:0] RST_SEL_LOW = 8'h30;
   localparam logic [7:0] RST_SEL_HIGH = 8'h06;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // control fields
   localparam int CTL_VIRTUAL_BIT = 7;
   localparam int CTL_HALF_SEC_BIT = 6;
   localparam int CTL_RUN_BIT = 0;
   // trim fields: bit 12 sign, bits 11..0 magnitude
   localparam int TRIM_SIGN_BIT = 12;
   localparam int TRIM_MAG_W = 12;
   localparam int TRIM_ACC_W = 23;
   // divider: 15 bits make one second, taps are the top eight
   localparam int DIV_W = 15;
   localparam int TAP_LSB = 7;
   localparam int TAP_HALF_SEC = 6;
   localparam int TAP_ONE_SEC = 7;
   // port output types
   localparam logic [3:0] PM_CMOS = 4'b0010;
   localparam logic [3:0] PM_OD = 4'b1010;
   localparam logic [3:0] PM_OD_PULL = 4'b1111;
endpackage

// [rtl/slow_time_base_counter.sv]
// slow time base counter with apb registers, tick interrupts and pulse pins
//
// The APB slave port was left to the implementer.
module slow_time_base_counter #(
   parameter int ADDR_W = 18,
   parameter bit ADJUST_EN = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic slow_clock,
   input wire logic fast_clock_ok,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tick_irq_zero,
   output logic tick_irq_one,
   output logic tick_irq_two,
   output logic adc_trigger,
   output logic rtc_half_second_tick,
   input wire logic [3:0] port_mode_first,
   input wire logic [3:0] port_mode_second,
   output logic pulse_out_first,
   output logic pulse_out_first_oe,
   output logic pulse_out_first_pullup,
   output logic pulse_out_second,
   output logic pulse_out_second_oe,
   output logic pulse_out_second_pullup
);
   import slow_tb_pkg::*;

   typedef enum logic [1:0] {
      AP_IDLE = 2'b00,
      AP_ACCESS = 2'b01
   } apb_state_t;

   apb_state_t apb_reg;
   logic [7:0] control_reg;
   logic [7:0] trim_low_reg;
   logic [7:0] trim_high_reg;
   logic [7:0] sel_low_reg;
   logic [7:0] sel_high_reg;
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] rtc_reg;
   logic [TRIM_ACC_W-1:0] acc_reg;
   logic slow_prev_reg;
   logic run_reg;
   logic [2:0] sel_prev_reg;
   logic [DIV_W-1:0] rtc_next;
   logic [TRIM_ACC_W:0] acc_sum;
   logic slow_tick;
   logic wr_now;
   logic [15:0] idx;
   logic [7:0] taps;
   logic [7:0] rtc_taps;
   logic [2:0] sel_now;
   logic [2:0] falls;
   logic [7:0] rd_byte;
   logic mapped;
   logic plain_pick;
   logic rtc_pick;
   logic first_src;
   logic second_src;

   function automatic logic tap_pick(input logic [7:0] t, input logic [2:0] code);
      tap_pick = t[code];
   endfunction

   function automatic logic [2:0] pin_drive(input logic [3:0] mode, input logic val);
      // {out, oe, pullup}; open drain only pulls low
      case (mode)
         PM_CMOS: pin_drive = {val, 1'b1, 1'b0};
         PM_OD: pin_drive = {1'b0, ~val, 1'b0};
         PM_OD_PULL: pin_drive = {1'b0, ~val, 1'b1};
         default: pin_drive = 3'b000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   assign idx = 16'(paddr >> 2);
   assign wr_now = clk_en && psel && penable && pwrite && pready;

   always_comb begin
      mapped = 1'b1;
      case (idx)
         IDX_TAP_VALUE: rd_byte = taps;
         IDX_CONTROL: rd_byte = control_reg;
         IDX_RTC_TAP: rd_byte = rtc_taps;
         IDX_TRIM_LOW: rd_byte = trim_low_reg;
         IDX_TRIM_HIGH: rd_byte = trim_high_reg;
         IDX_SEL_LOW: rd_byte = sel_low_reg;
         IDX_SEL_HIGH: rd_byte = sel_high_reg;
         default: begin
            rd_byte = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   // answer one cycle after setup; no wait states
   always_ff @(posedge clk) begin
      if (!resetn) begin
         apb_reg <= AP_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         case (apb_reg)
            AP_IDLE: begin
               if (psel && !penable) begin
                  apb_reg <= AP_ACCESS;
                  pready <= 1'b1;
                  pslverr <= !mapped;
                  prdata <= {24'h00_0000, rd_byte};
               end
            end
            AP_ACCESS: begin
               apb_reg <= AP_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
               prdata <= 32'h0000_0000;
            end
            default: apb_reg <= AP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         control_reg <= RST_CONTROL;
         trim_low_reg <= RST_ZERO;
         trim_high_reg <= RST_ZERO;
         sel_low_reg <= RST_SEL_LOW;
         sel_high_reg <= RST_SEL_HIGH;
      end else if (wr_now && mapped) begin
         case (idx)
            IDX_CONTROL: control_reg <= {pwdata[7:6], 5'b00000, pwdata[0]};
            IDX_TRIM_LOW: trim_low_reg <= pwdata[7:0];
            IDX_TRIM_HIGH: trim_high_reg <= {3'b000, pwdata[4:0]};
            IDX_SEL_LOW: sel_low_reg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            IDX_SEL_HIGH: sel_high_reg <= {5'b00000, pwdata[2:0]};
            default: control_reg <= control_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // divider

   assign slow_tick = slow_prev_reg && !slow_clock;
   assign taps = div_reg[DIV_W-1 -: 8];
   assign rtc_taps = ADJUST_EN ? rtc_reg[DIV_W-1 -: 8] : 8'h00;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         slow_prev_reg <= 1'b0;
      end else if (clk_en) begin
         slow_prev_reg <= slow_clock;
      end
   end

   // run bit is taken on a slow edge, so it lands within one slow cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         run_reg <= 1'b1;
      end else if (clk_en && slow_tick) begin
         run_reg <= control_reg[CTL_RUN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_reg <= '0;
      end else if (wr_now && idx == IDX_TAP_VALUE) begin
         div_reg <= '0;
      end else if (clk_en && slow_tick && run_reg) begin
         div_reg <= div_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frequency trim: a 2^-23 fraction accumulates per slow edge, its carry
   // skips (faster) or holds (slower) one rtc count; the step is 0.119 ppm

   assign acc_sum = {1'b0, acc_reg} + {12'h000, trim_high_reg[3:0], trim_low_reg};

   always_comb begin
      rtc_next = rtc_reg + 1'b1;
      if (acc_sum[TRIM_ACC_W]) begin
         if (trim_high_reg[TRIM_SIGN_BIT-8]) begin
            rtc_next = rtc_reg;
         end else begin
            rtc_next = rtc_reg + DIV_W'(2);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || !ADJUST_EN) begin
         rtc_reg <= '0;
         acc_reg <= '0;
      end else if (clk_en && slow_tick && run_reg) begin
         acc_reg <= acc_sum[TRIM_ACC_W-1:0];
         rtc_reg <= rtc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tick interrupts

   assign sel_now = {tap_pick(taps, sel_high_reg[2:0]),
                     tap_pick(taps, sel_low_reg[6:4]),
                     tap_pick(taps, sel_low_reg[2:0])};
   assign falls = sel_prev_reg & ~sel_now;

   // a select change or a clear may show as a fall; software masks it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sel_prev_reg <= 3'b000;
         tick_irq_zero <= 1'b0;
         tick_irq_one <= 1'b0;
         tick_irq_two <= 1'b0;
         adc_trigger <= 1'b0;
      end else if (clk_en) begin
         sel_prev_reg <= sel_now;
         tick_irq_zero <= falls[0];
         tick_irq_one <= falls[1];
         tick_irq_two <= falls[2];
         adc_trigger <= falls[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse pins; fast_clock_ok gates the virtual mode, which needs it

   assign plain_pick = control_reg[CTL_HALF_SEC_BIT] ? taps[TAP_HALF_SEC]
                                                      : taps[TAP_ONE_SEC];
   assign rtc_pick = control_reg[CTL_HALF_SEC_BIT] ? rtc_taps[TAP_HALF_SEC]
                                                    : rtc_taps[TAP_ONE_SEC];
   assign first_src = (ADJUST_EN && control_reg[CTL_VIRTUAL_BIT] && fast_clock_ok)
                      ? rtc_pick : plain_pick;
   assign second_src = ADJUST_EN ? rtc_pick : plain_pick;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         {pulse_out_first, pulse_out_first_oe, pulse_out_first_pullup} <= 3'b000;
         {pulse_out_second, pulse_out_second_oe, pulse_out_second_pullup} <= 3'b000;
         rtc_half_second_tick <= 1'b0;
      end else if (clk_en) begin
         {pulse_out_first, pulse_out_first_oe, pulse_out_first_pullup} <=
            pin_drive(port_mode_first, first_src);
         {pulse_out_second, pulse_out_second_oe, pulse_out_second_pullup} <=
            pin_drive(port_mode_second, second_src);
         rtc_half_second_tick <= rtc_pick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence tap_write_s;
      wr_now && idx == IDX_TAP_VALUE;
   endsequence

   sequence step_s;
      clk_en && slow_tick && run_reg && !(wr_now && idx == IDX_TAP_VALUE);
   endsequence

   tap_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      tap_write_s |=> div_reg == '0 && taps == 8'h00)
      else $error("tap write did not clear divider");

   div_step_a: assert property (@(posedge clk) disable iff (!resetn)
      step_s |=> div_reg == $past(div_reg) + 1'b1)
      else $error("divider did not step on slow edge");

   div_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (clk_en && !run_reg && !(wr_now && idx == IDX_TAP_VALUE)) |=> div_reg == $past(div_reg))
      else $error("divider moved while stopped");

   run_lag_a: assert property (@(posedge clk) disable iff (!resetn)
      (clk_en && slow_tick && run_reg != control_reg[CTL_RUN_BIT])
      |=> run_reg == $past(control_reg[CTL_RUN_BIT]))
      else $error("run bit not applied on slow edge");

   irq_fall_a: assert property (@(posedge clk) disable iff (!resetn)
      (clk_en && sel_prev_reg[0] && !sel_now[0]) |=> tick_irq_zero)
      else $error("falling tap gave no request");

   irq_cause_a: assert property (@(posedge clk) disable iff (!resetn)
      tick_irq_one |-> $past(sel_now[1], 2) && !$past(sel_now[1]))
      else $error("request without tap fall");

   adc_trig_a: assert property (@(posedge clk) disable iff (!resetn)
      adc_trigger == tick_irq_zero)
      else $error("trigger differs from channel zero");

   sel_map_a: assert property (@(posedge clk) disable iff (!resetn)
      (sel_high_reg[2:0] == 3'b111) |-> sel_now[2] == div_reg[DIV_W-1])
      else $error("code 111 did not pick the one second tap");

   pin_cmos_a: assert property (@(posedge clk) disable iff (!resetn)
      (clk_en && port_mode_second == PM_CMOS) |=> pulse_out_second_oe
      && pulse_out_second == $past(second_src))
      else $error("push-pull pin not driven");

   pin_od_a: assert property (@(posedge clk) disable iff (!resetn)
      (clk_en && port_mode_first == PM_OD_PULL) |=> !pulse_out_first
      && pulse_out_first_pullup && pulse_out_first_oe == !$past(first_src))
      else $error("open drain pin wrong");

   reg_rst_a: assert property (@(posedge clk)
      !resetn |=> control_reg == RST_CONTROL && sel_low_reg == RST_SEL_LOW)
      else $error("reset values wrong");
endmodule

// [verification/irq_sink.sv]
// far-side model: interrupt controller pending counters and trigger input
module irq_sink (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cnt_clr,
   input wire logic tick_irq_zero,
   input wire logic tick_irq_one,
   input wire logic tick_irq_two,
   input wire logic adc_trigger,
   output logic [15:0] cnt_zero,
   output logic [15:0] cnt_one,
   output logic [15:0] cnt_two,
   output logic [15:0] cnt_adc
);
   timeunit 1ns;
   timeprecision 1ns;
   // counting high cycles: a stretched pulse counts twice and shows up
   always_ff @(posedge clk) begin
      if (!resetn || cnt_clr) begin
         cnt_zero <= 16'h0000;
         cnt_one <= 16'h0000;
         cnt_two <= 16'h0000;
         cnt_adc <= 16'h0000;
      end else begin
         cnt_zero <= cnt_zero + 16'(tick_irq_zero);
         cnt_one <= cnt_one + 16'(tick_irq_one);
         cnt_two <= cnt_two + 16'(tick_irq_two);
         cnt_adc <= cnt_adc + 16'(adc_trigger);
      end
   end
endmodule

// [verification/slow_time_base_counter_tb.sv]
// self-checking bench for the slow time base counter
module slow_time_base_counter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import slow_tb_pkg::*;
   logic clk = 0, resetn = 0, slow = 0, psel = 0, penable = 0, pwrite = 0, cnt_clr = 0;
   logic ce = 1;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, irq0, irq1, irq2, adc, p1, p1_oe, p1_pu, p2, rtick;
   logic [3:0] mode1 = 4'h0, mode2 = 4'h0;
   logic [15:0] c0, c1, c2, ca;
   logic [7:0] rd;
   logic er;
   int err_count = 0, check_count = 0;
   //////////////////////////////////////////////////////////////////////
   slow_time_base_counter u_slow_time_base_counter (.clk(clk), .resetn(resetn),
      .clk_en(ce), .slow_clock(slow), .fast_clock_ok(1'b0), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_irq_zero(irq0),
      .tick_irq_one(irq1), .tick_irq_two(irq2), .adc_trigger(adc),
      .rtc_half_second_tick(rtick), .port_mode_first(mode1), .port_mode_second(mode2),
      .pulse_out_first(p1), .pulse_out_first_oe(p1_oe),
      .pulse_out_first_pullup(p1_pu), .pulse_out_second(p2),
      .pulse_out_second_oe(), .pulse_out_second_pullup());
   irq_sink u_irq_sink (.clk(clk), .resetn(resetn), .cnt_clr(cnt_clr),
      .tick_irq_zero(irq0), .tick_irq_one(irq1), .tick_irq_two(irq2),
      .adc_trigger(adc), .cnt_zero(c0), .cnt_one(c1), .cnt_two(c2), .cnt_adc(ca));
   initial begin
      forever #10 clk = ~clk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // held until pready is seen high at a rising edge, then released
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 16'h0001, 16'h0000);
   endtask
   task automatic rchk(input string what, input logic [15:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(what, {8'h00, exp}, {8'h00, rd});
   endtask
   // two clk per slow cycle; settle time lets the sampler see the last fall
   task automatic falls(input int n);
      repeat (n) begin
         @(posedge clk) slow <= 1'b1;
         @(posedge clk) slow <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask
   // clear taps, then drop the pending counts the clear may have caused
   task automatic clear_taps();
      apb(1'b1, IDX_TAP_VALUE, 8'h5a);
      repeat (3) @(posedge clk);
      cnt_clr <= 1'b1;
      @(posedge clk) cnt_clr <= 1'b0;
      @(posedge clk);
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      rchk("tap", IDX_TAP_VALUE, 8'h00);
      rchk("ctl", IDX_CONTROL, 8'h01);
      rchk("rtc", IDX_RTC_TAP, 8'h00);
      rchk("trim_lo", IDX_TRIM_LOW, 8'h00);
      rchk("trim_hi", IDX_TRIM_HIGH, 8'h00);
      rchk("sel_lo", IDX_SEL_LOW, 8'h30);
      rchk("sel_hi", IDX_SEL_HIGH, 8'h06);
      apb(1'b0, 16'hf061, 8'h00);
      chk("unmapped err", 16'h0001, {15'h0000, er});
      $display("test reset values done");
   endtask
   task automatic t_reg_rw();
      apb(1'b1, IDX_TRIM_LOW, 8'ha5);
      apb(1'b1, IDX_TRIM_HIGH, 8'hff);
      rchk("trim_lo", IDX_TRIM_LOW, 8'ha5);
      rchk("trim_hi", IDX_TRIM_HIGH, 8'h1f);
      apb(1'b1, IDX_SEL_HIGH, 8'hff);
      rchk("sel_hi", IDX_SEL_HIGH, 8'h07);
      apb(1'b1, IDX_TRIM_LOW, 8'h00);
      apb(1'b1, IDX_TRIM_HIGH, 8'h00);
      $display("test register access done");
   endtask
   task automatic t_tap_count();
      clear_taps();
      rchk("tap clr", IDX_TAP_VALUE, 8'h00);
      falls(127);
      rchk("tap 127", IDX_TAP_VALUE, 8'h00);
      falls(1);
      rchk("tap 128", IDX_TAP_VALUE, 8'h01);
      falls(127);
      rchk("tap 255", IDX_TAP_VALUE, 8'h01);
      falls(1);
      rchk("tap 256", IDX_TAP_VALUE, 8'h02);
      $display("test tap counting done");
   endtask
   // run bit takes hold on the first slow fall after the write
   task automatic t_run_ctl();
      apb(1'b1, IDX_CONTROL, 8'h00);
      falls(2);
      clear_taps();
      falls(300);
      rchk("tap stopped", IDX_TAP_VALUE, 8'h00);
      apb(1'b1, IDX_CONTROL, 8'h01);
      falls(130);
      rchk("tap restarted", IDX_TAP_VALUE, 8'h01);
      // clock enable low: 200 falls must leave the divider where it was
      ce <= 1'b0;
      falls(200);
      ce <= 1'b1;
      rchk("tap frozen", IDX_TAP_VALUE, 8'h01);
      $display("test run control done");
   endtask
   // codes above 4 left out: their periods would dominate the run time
   task automatic t_irq_sel();
      for (int c = 0; c < 5; c++) begin
         apb(1'b1, IDX_SEL_LOW, 8'h10);
         apb(1'b1, IDX_SEL_HIGH, 8'(c));
         clear_taps();
         falls((256 << c) - 1);
         chk("irq2 early", 16'h0000, c2);
         falls(1);
         chk("irq2 fall", 16'h0001, c2);
         if (c == 0) begin
            chk("irq0", 16'h0001, c0);
            chk("adc", 16'h0001, ca);
            chk("irq1", 16'h0000, c1);
         end
      end
      $display("test interrupt select done");
   endtask
   // mid-run reset puts the rtc counter level with the divider, trim being zero
   task automatic t_pins();
      logic [3:0] m [4] = '{4'b0010, 4'b1010, 4'b1111, 4'b0000};
      logic [2:0] e [2][4] = '{'{3'b010, 3'b010, 3'b011, 3'b000},
                              '{3'b110, 3'b000, 3'b001, 3'b000}};
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rchk("ctl again", IDX_CONTROL, 8'h01);
      apb(1'b1, IDX_CONTROL, 8'h41);
      mode2 <= PM_CMOS;
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) begin
            mode1 <= m[i];
            repeat (3) @(posedge clk);
            chk("pin out oe pu", {13'h0000, e[k][i]}, {13'h0000, p1, p1_oe, p1_pu});
         end
         chk("pin two", {15'h0000, 1'(k)}, {15'h0000, p2});
         chk("rtc tick", {15'h0000, 1'(k)}, {15'h0000, rtick});
         if (k == 0) falls(8192);
      end
      rchk("tap half", IDX_TAP_VALUE, 8'h40);
      rchk("rtc half", IDX_RTC_TAP, 8'h40);
      apb(1'b1, IDX_CONTROL, 8'h01);
      repeat (3) @(posedge clk);
      chk("rtc tick 1 hz", 16'h0000, {15'h0000, rtick});
      chk("pin two 1 hz", 16'h0000, {15'h0000, p2});
      $display("test pin modes done");
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset_vals();
      t_reg_rw();
      t_tap_count();
      t_run_ctl();
      t_irq_sel();
      t_pins();
      test_done();
   end
   // all scenarios together stay well below this span
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      test_done();
   end
endmodule
